// ---- design/udep_core.sv ----
// Purpose: endpoint buffer manager and dma handshake of a usb device
// Assumes: all inputs synchronous to clock; sie and firmware give pulses
// Notes: indices 0/1 are control out/in, 2..15 are endpoints 1..14
`timescale 1ns/1ps
`include "udep_map.svh"

module udep_core (
	// clock and resets
	input wire logic clock,
	input wire logic rst,
	input wire logic usb_bus_reset,
	// endpoint configuration
	input wire logic cfg_write,
	input wire logic [3:0] cfg_index,
	input wire logic endpoint_buffer_enable,
	input wire logic endpoint_direction_bit,
	input wire logic endpoint_isochronous_select,
	input wire logic cfg_double_buffer,
	input wire logic [3:0] endpoint_size_code,
	output logic config_complete,
	output logic [15:0] alloc_total_bytes,
	output logic alloc_overflow,
	output logic cfg_reserved_size,
	// dma configuration
	input wire logic dma_enable_set,
	input wire logic dma_enable_clear,
	input wire logic [3:0] dma_endpoint_index,
	input wire logic [4:0] dma_burst_bytes,
	input wire logic [15:0] dma_byte_count,
	output logic dma_handler_enable,
	output logic dma_transfer_done,
	// dma handshake pins
	input wire logic single_dma_channel_select,
	output logic periph_dma_request,
	input wire logic periph_dma_acknowledge,
	output logic host_dma_request_pin,
	input wire logic host_dma_acknowledge_pin,
	input wire logic host_ctrl_dma_request,
	output logic host_ctrl_dma_acknowledge,
	input wire logic dma_write_strobe,
	input wire logic [7:0] dma_write_data,
	input wire logic dma_read_strobe,
	output logic [7:0] dma_read_data,
	// buffer memory side
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [3:0] mem_wr_endpoint,
	output logic [7:0] mem_wr_byte,
	output logic mem_rd_strobe,
	input wire logic [7:0] mem_rd_byte,
	// serial engine events
	input wire logic sie_tx_done,
	input wire logic sie_rx_done,
	input wire logic sie_setup,
	input wire logic [3:0] sie_endpoint,
	input wire logic [9:0] sie_rx_length,
	output logic [15:0] buf_ping_full,
	output logic [15:0] buf_pong_full,
	// firmware commands
	input wire logic cmd_valid,
	input wire udep_pkg::udep_cmd_t cmd_op,
	input wire logic [3:0] cmd_endpoint,
	output logic cmd_refused,
	output logic [7:0] status_byte,
	output logic [15:0] endpoint_event_flag
);

	logic [15:0] ep_en_ff;
	logic [15:0] ep_dir_ff;
	logic [15:0] ep_iso_ff;
	logic [15:0] ep_dbl_ff;
	logic [3:0] ep_size_ff [`UDEP_EP_COUNT];
	logic [9:0] len_ping_ff [`UDEP_EP_COUNT];
	logic [9:0] len_pong_ff [`UDEP_EP_COUNT];
	logic [4:0] cfg_seq_ff;
	logic cfg_done_ff;
	logic dma_en_ff;
	logic [15:0] dma_cnt_ff;
	logic [4:0] burst_cnt_ff;
	udep_pkg::udep_burst_t burst_st_ff;
	logic dma_sel_ff;
	logic [10:0] dma_len_ff;
	logic [15:0] ping_ff;
	logic [15:0] pong_ff;
	logic [15:0] nxt_ping;
	logic [15:0] nxt_pong;
	logic [1:0] setup_lock_ff;
	logic [15:0] evt_ff;
	logic [7:0] rd_data_ff;
	logic [7:0] status_ff;
	logic refused_ff;
	logic done_ff;
	logic [15:0] alloc_sum;
	logic ack;
	logic req;
	logic acc;
	logic ep_ok;
	logic tx_mode;
	logic cur_full;
	logic fifo_in_ready;
	logic [10:0] max_pkt;
	logic [10:0] rx_pkt;
	logic burst_hit;
	logic term_now;
	logic fin_tx;
	logic fin_rx;
	logic cmd_lock;
	logic cfg_flush;
	logic [3:0] di;
	logic [11:0] fifo_out;

	// max packet bytes from size code
	function automatic logic [10:0] udep_size_bytes(input logic iso, input logic [3:0] code);
		logic [10:0] r;
		r = '0;
		if (!iso)
			r = (code <= `UDEP_NONISO_MAX_CODE) ? (`UDEP_NONISO_BASE << code) : 11'h000;
		else
			case (code)
				4'h0: r = 11'h010;
				4'h1: r = 11'h020;
				4'h2: r = 11'h030;
				4'h3: r = 11'h040;
				4'h4: r = 11'h060;
				4'h5: r = 11'h080;
				4'h6: r = 11'h0A0;
				4'h7: r = 11'h0C0;
				4'h8: r = 11'h100;
				4'h9: r = 11'h140;
				4'hA: r = 11'h180;
				4'hB: r = 11'h200;
				4'hC: r = 11'h280;
				4'hD: r = 11'h300;
				4'hE: r = 11'h380;
				default: r = 11'h3FF;
			endcase
		return r;
	endfunction : udep_size_bytes

	// physical storage of enabled endpoints
	always_comb
	begin
		alloc_sum = '0;
		for (int i = 0; i < `UDEP_EP_COUNT; i++)
		begin
			if (i < 2)
				alloc_sum = alloc_sum + 16'(`UDEP_CTRL_BYTES);
			else if (ep_en_ff[i])
				alloc_sum = alloc_sum + (16'(udep_size_bytes(ep_iso_ff[i], ep_size_ff[i])) << ep_dbl_ff[i]);
		end
	end

	assign alloc_total_bytes = alloc_sum;
	assign alloc_overflow = (alloc_sum > `UDEP_MAX_STORAGE);
	assign cfg_reserved_size = ~endpoint_isochronous_select & (endpoint_size_code > `UDEP_NONISO_MAX_CODE);
	assign config_complete = cfg_done_ff;

	// endpoint configuration, control pair fixed
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset)
		begin
			ep_en_ff <= `UDEP_CTRL_EN_MASK;
			ep_dir_ff <= `UDEP_CTRL_DIR_MASK;
			ep_iso_ff <= '0;
			ep_dbl_ff <= '0;
			for (int i = 0; i < `UDEP_EP_COUNT; i++)
				ep_size_ff[i] <= '0;
		end
		else if (cfg_write && cfg_index >= `UDEP_FIRST_DMA_EP)
		begin
			ep_en_ff[cfg_index] <= endpoint_buffer_enable;
			ep_dir_ff[cfg_index] <= endpoint_direction_bit;
			ep_iso_ff[cfg_index] <= endpoint_isochronous_select;
			ep_dbl_ff[cfg_index] <= cfg_double_buffer;
			ep_size_ff[cfg_index] <= endpoint_size_code;
		end
	end

	// in-order configuration sequence
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset)
		begin
			cfg_seq_ff <= '0;
			cfg_done_ff <= 1'b0;
		end
		else if (cfg_write)
		begin
			if ({1'b0, cfg_index} == cfg_seq_ff)
				cfg_seq_ff <= cfg_seq_ff + 5'h01;
			else
				cfg_seq_ff <= (cfg_index == `UDEP_CTRL_OUT) ? 5'h01 : 5'h00;
			cfg_done_ff <= ({1'b0, cfg_index} == cfg_seq_ff) && (cfg_seq_ff == `UDEP_CFG_SEQ_DONE - 5'h01);
		end
	end

	assign cfg_flush = cfg_write && (cfg_index >= `UDEP_FIRST_DMA_EP) && ((|ping_ff) || (|pong_ff)) &&
		((ep_en_ff[cfg_index] != endpoint_buffer_enable) || (ep_iso_ff[cfg_index] != endpoint_isochronous_select)
		|| (ep_size_ff[cfg_index] != endpoint_size_code) || (ep_dbl_ff[cfg_index] != cfg_double_buffer));

	// dma selection and handshake
	assign di = dma_endpoint_index;
	assign ep_ok = (di >= `UDEP_FIRST_DMA_EP) && ep_en_ff[di];
	assign tx_mode = ep_dir_ff[di];
	assign cur_full = dma_sel_ff ? pong_ff[di] : ping_ff[di];
	assign max_pkt = udep_size_bytes(ep_iso_ff[di], ep_size_ff[di]);
	assign rx_pkt = {1'b0, (dma_sel_ff ? len_pong_ff[di] : len_ping_ff[di])};
	assign req = dma_en_ff && ep_ok && (burst_st_ff == udep_pkg::UDEP_BURST_RUN) &&
		(tx_mode ? (!cur_full && fifo_in_ready) : cur_full);
	assign ack = single_dma_channel_select ? host_dma_acknowledge_pin : periph_dma_acknowledge;
	assign acc = ack && req && (tx_mode ? dma_write_strobe : dma_read_strobe);
	assign periph_dma_request = single_dma_channel_select ? 1'b0 : req;
	assign host_dma_request_pin = single_dma_channel_select ? req : host_ctrl_dma_request;
	assign host_ctrl_dma_acknowledge = single_dma_channel_select ? 1'b0 : host_dma_acknowledge_pin;
	assign burst_hit = acc && ((burst_cnt_ff + 5'h01) >= ((dma_burst_bytes == 5'h00) ? 5'h01 : dma_burst_bytes));
	assign term_now = dma_en_ff && (dma_enable_clear || (acc && dma_cnt_ff == 16'h0001));
	assign fin_tx = tx_mode && ((acc && (dma_len_ff + 11'h001 >= max_pkt)) ||
		(term_now && (dma_len_ff != 11'h000 || acc)));
	assign fin_rx = !tx_mode && ((acc && (dma_len_ff + 11'h001 >= rx_pkt)) || (term_now && cur_full));
	assign mem_rd_strobe = acc && !tx_mode;
	assign dma_handler_enable = dma_en_ff;
	assign dma_transfer_done = done_ff;
	assign dma_read_data = rd_data_ff;

	// handler enable and byte counter
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset)
		begin
			dma_en_ff <= 1'b0;
			dma_cnt_ff <= '0;
			done_ff <= 1'b0;
		end
		else
		begin
			done_ff <= term_now;
			if (term_now)
				dma_en_ff <= 1'b0;
			else if (dma_enable_set)
				dma_en_ff <= 1'b1;
			if (dma_enable_set && !dma_en_ff)
				dma_cnt_ff <= dma_byte_count;
			else if (acc && dma_cnt_ff != 16'h0000)
				dma_cnt_ff <= dma_cnt_ff - 16'h0001;
		end
	end

	// burst length pacing
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset)
		begin
			burst_st_ff <= udep_pkg::UDEP_BURST_RUN;
			burst_cnt_ff <= '0;
		end
		else
			case (burst_st_ff)
				udep_pkg::UDEP_BURST_RUN:
				begin
					if (burst_hit)
					begin
						burst_st_ff <= udep_pkg::UDEP_BURST_WAIT;
						burst_cnt_ff <= '0;
					end
					else if (acc || !ack)
						burst_cnt_ff <= ack ? burst_cnt_ff + 5'h01 : 5'h00;
				end
				udep_pkg::UDEP_BURST_WAIT:
				begin
					if (!ack)
						burst_st_ff <= udep_pkg::UDEP_BURST_RUN;
				end
				default:
					burst_st_ff <= udep_pkg::UDEP_BURST_RUN;
			endcase
	end

	// dma position within the current buffer
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset || cfg_flush)
		begin
			dma_sel_ff <= 1'b0;
			dma_len_ff <= '0;
		end
		else if (!dma_en_ff)
			dma_sel_ff <= ep_dbl_ff[di] & (ep_dir_ff[di] ? ping_ff[di] : ~ping_ff[di]);
		else if (fin_tx || fin_rx)
		begin
			dma_sel_ff <= ep_dbl_ff[di] ? ~dma_sel_ff : 1'b0;
			dma_len_ff <= '0;
		end
		else if (acc)
			dma_len_ff <= dma_len_ff + 11'h001;
	end

	// read data to the dma controller
	always_ff @(posedge clock)
	begin
		if (rst)
			rd_data_ff <= '0;
		else if (acc && !tx_mode)
			rd_data_ff <= mem_rd_byte;
	end

	// received packet lengths
	always_ff @(posedge clock)
	begin
		if (sie_setup)
			len_ping_ff[`UDEP_CTRL_OUT] <= sie_rx_length;
		else if (sie_rx_done && !ping_ff[sie_endpoint])
			len_ping_ff[sie_endpoint] <= sie_rx_length;
		else if (sie_rx_done && ep_dbl_ff[sie_endpoint])
			len_pong_ff[sie_endpoint] <= sie_rx_length;
	end

	assign cmd_lock = (cmd_endpoint < `UDEP_FIRST_DMA_EP) && (|setup_lock_ff);

	// buffer full flags: clears first, sets win, cfg_flush clears all last
	always_comb
	begin
		nxt_ping = ping_ff;
		nxt_pong = pong_ff;
		if (cmd_valid && cmd_op == udep_pkg::UDEP_CMD_CLEAR && !cmd_lock && !ep_dir_ff[cmd_endpoint])
		begin
			if (ping_ff[cmd_endpoint])
				nxt_ping[cmd_endpoint] = 1'b0;
			else
				nxt_pong[cmd_endpoint] = 1'b0;
		end
		if (sie_tx_done)
		begin
			if (ping_ff[sie_endpoint])
				nxt_ping[sie_endpoint] = 1'b0;
			else
				nxt_pong[sie_endpoint] = 1'b0;
		end
		if (fin_rx)
		begin
			if (dma_sel_ff)
				nxt_pong[di] = 1'b0;
			else
				nxt_ping[di] = 1'b0;
		end
		if (sie_setup)
			nxt_ping[`UDEP_CTRL_IN] = 1'b0;
		if (cmd_valid && cmd_op == udep_pkg::UDEP_CMD_VALIDATE && !cmd_lock && ep_dir_ff[cmd_endpoint])
		begin
			if (!ping_ff[cmd_endpoint])
				nxt_ping[cmd_endpoint] = 1'b1;
			else if (ep_dbl_ff[cmd_endpoint])
				nxt_pong[cmd_endpoint] = 1'b1;
		end
		if (sie_rx_done && ep_en_ff[sie_endpoint])
		begin
			if (!ping_ff[sie_endpoint])
				nxt_ping[sie_endpoint] = 1'b1;
			else if (ep_dbl_ff[sie_endpoint])
				nxt_pong[sie_endpoint] = 1'b1;
		end
		if (fin_tx)
		begin
			if (dma_sel_ff)
				nxt_pong[di] = 1'b1;
			else
				nxt_ping[di] = 1'b1;
		end
		if (sie_setup)
			nxt_ping[`UDEP_CTRL_OUT] = 1'b1;
		if (cfg_flush)
		begin
			nxt_ping = '0;
			nxt_pong = '0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset)
		begin
			ping_ff <= '0;
			pong_ff <= '0;
		end
		else
		begin
			ping_ff <= nxt_ping & ep_en_ff;
			pong_ff <= nxt_pong & ep_en_ff & ep_dbl_ff;
		end
	end

	assign buf_ping_full = ping_ff;
	assign buf_pong_full = pong_ff;

	// setup lock on the control pair
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset)
			setup_lock_ff <= '0;
		else if (sie_setup)
			setup_lock_ff <= 2'h3;
		else if (cmd_valid && cmd_op == udep_pkg::UDEP_CMD_ACK_SETUP && cmd_endpoint < `UDEP_FIRST_DMA_EP)
			setup_lock_ff[cmd_endpoint[0]] <= 1'b0;
	end

	// endpoint event flags
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset)
			evt_ff <= '0;
		else
			for (int i = 0; i < `UDEP_EP_COUNT; i++)
				if ((sie_tx_done || sie_rx_done) && sie_endpoint == 4'(i))
					evt_ff[i] <= 1'b1;
				else if (sie_setup && i == 0)
					evt_ff[i] <= 1'b1;
				else if (cmd_valid && cmd_op == udep_pkg::UDEP_CMD_READ_STATUS && cmd_endpoint == 4'(i))
					evt_ff[i] <= 1'b0;
	end

	assign endpoint_event_flag = evt_ff;

	// status byte and command refusal
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset)
		begin
			status_ff <= '0;
			refused_ff <= 1'b0;
		end
		else
		begin
			refused_ff <= cmd_valid && cmd_lock &&
				(cmd_op == udep_pkg::UDEP_CMD_VALIDATE || cmd_op == udep_pkg::UDEP_CMD_CLEAR);
			if (cmd_valid && cmd_op == udep_pkg::UDEP_CMD_READ_STATUS)
			begin
				status_ff[`UDEP_ST_EN] <= ep_en_ff[cmd_endpoint];
				status_ff[`UDEP_ST_DIR] <= ep_dir_ff[cmd_endpoint];
				status_ff[`UDEP_ST_ISO] <= ep_iso_ff[cmd_endpoint];
				status_ff[`UDEP_ST_DBL] <= ep_dbl_ff[cmd_endpoint];
				status_ff[`UDEP_ST_PING] <= ping_ff[cmd_endpoint];
				status_ff[`UDEP_ST_PONG] <= pong_ff[cmd_endpoint];
				status_ff[`UDEP_ST_EVT] <= evt_ff[cmd_endpoint];
				status_ff[`UDEP_ST_LOCK] <= (cmd_endpoint < `UDEP_FIRST_DMA_EP) && (|setup_lock_ff);
			end
		end
	end

	assign status_byte = status_ff;
	assign cmd_refused = refused_ff;

	// write data path toward buffer memory
	udep_fifo #(
		.WIDTH(`UDEP_FIFO_WIDTH),
		.DEPTH(`UDEP_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(acc && tx_mode),
		.in_ready(fifo_in_ready),
		.in_data({di, dma_write_data}),
		.out_valid(mem_wr_valid),
		.out_ready(mem_wr_ready),
		.out_data(fifo_out)
	);

	assign mem_wr_endpoint = fifo_out[11:8];
	assign mem_wr_byte = fifo_out[7:0];

endmodule : udep_core

// ---- design/udep_map.svh ----
// Purpose: constants of the endpoint buffer and dma handshake block
// Assumes: included by its bare name
// Notes: definitions only
`ifndef UDEP_MAP_SVH
`define UDEP_MAP_SVH

`define UDEP_EP_COUNT 16
`define UDEP_CTRL_OUT 4'h0
`define UDEP_CTRL_IN 4'h1
`define UDEP_FIRST_DMA_EP 4'h2
`define UDEP_CTRL_EN_MASK 16'h0003
`define UDEP_CTRL_DIR_MASK 16'h0002
`define UDEP_CTRL_BYTES 11'h040
`define UDEP_MAX_STORAGE 16'h099E
`define UDEP_NONISO_MAX_CODE 4'h3
`define UDEP_NONISO_BASE 11'h008
`define UDEP_CFG_SEQ_DONE 5'h10
`define UDEP_FIFO_WIDTH 12
`define UDEP_FIFO_DEPTH 8
`define UDEP_ST_EN 0
`define UDEP_ST_DIR 1
`define UDEP_ST_ISO 2
`define UDEP_ST_DBL 3
`define UDEP_ST_PING 4
`define UDEP_ST_PONG 5
`define UDEP_ST_EVT 6
`define UDEP_ST_LOCK 7

`endif

// ---- design/udep_pkg.sv ----
// Purpose: shared types of the endpoint buffer and dma handshake block
// Assumes: nothing
// Notes: used as udep_pkg::name
package udep_pkg;

	typedef enum logic [1:0] {
		UDEP_CMD_VALIDATE,
		UDEP_CMD_CLEAR,
		UDEP_CMD_ACK_SETUP,
		UDEP_CMD_READ_STATUS
	} udep_cmd_t;

	typedef enum logic [1:0] {
		UDEP_BURST_RUN,
		UDEP_BURST_WAIT
	} udep_burst_t;

endpackage : udep_pkg

// ---- design/udep_fifo.sv ----
// Purpose: small fifo between dma write strobes and buffer memory
// Assumes: one clock, synchronous active high reset
// Notes: full and empty are exact; ready low stalls the source
`timescale 1ns/1ps
module udep_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;

	assign in_ready = (count_ff != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (count_ff != '0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage
	always_ff @(posedge clock)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data;
	end

	// pointers and fill level
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
			if (push && !pop)
				count_ff <= count_ff + (AW+1)'(1);
			else if (pop && !push)
				count_ff <= count_ff - (AW+1)'(1);
		end
	end

endmodule : udep_fifo

// ---- testbench/udep_core_props.sv ----
// Purpose: port checker of udep_core
// Assumes: one clock, rst synchronous active high
// Notes: bound to every udep_core below
`timescale 1ns/1ps
module udep_core_props (
	// clock and resets
	input wire logic clock,
	input wire logic rst,
	input wire logic usb_bus_reset,
	// dma
	input wire logic dma_enable_clear,
	input wire logic [3:0] dma_endpoint_index,
	input wire logic [4:0] dma_burst_bytes,
	input wire logic dma_handler_enable,
	input wire logic dma_transfer_done,
	input wire logic single_dma_channel_select,
	input wire logic periph_dma_request,
	input wire logic periph_dma_acknowledge,
	input wire logic host_dma_request_pin,
	input wire logic host_dma_acknowledge_pin,
	input wire logic host_ctrl_dma_request,
	input wire logic host_ctrl_dma_acknowledge,
	input wire logic dma_write_strobe,
	input wire logic dma_read_strobe,
	// events and commands
	input wire logic sie_tx_done,
	input wire logic sie_rx_done,
	input wire logic sie_setup,
	input wire logic [15:0] buf_ping_full,
	input wire logic cmd_valid,
	input wire udep_pkg::udep_cmd_t cmd_op,
	input wire logic [3:0] cmd_endpoint,
	input wire logic cmd_refused,
	input wire logic [15:0] endpoint_event_flag
);
	logic [4:0] bcnt_ff;
	logic [4:0] beff;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	assign beff = (dma_burst_bytes == 5'h00) ? 5'h01 : dma_burst_bytes;
	always_ff @(posedge clock)
	begin
		if (rst || usb_bus_reset || !periph_dma_acknowledge)
			bcnt_ff <= 5'h00;
		else if (periph_dma_request && (dma_write_strobe || dma_read_strobe))
			bcnt_ff <= bcnt_ff + 5'h01;
	end
	a_req_handler_off: assert property (!dma_handler_enable |-> !periph_dma_request)
		else $error("request while handler off");
	a_req_ctrl_index: assert property (dma_endpoint_index < 4'h2 |-> !periph_dma_request)
		else $error("request for a control index");
	a_route_to_host: assert property (single_dma_channel_select |-> !periph_dma_request && !host_ctrl_dma_acknowledge)
		else $error("handshake not moved to host pins");
	a_route_pass_host: assert property (!single_dma_channel_select |->
		host_dma_request_pin == host_ctrl_dma_request && host_ctrl_dma_acknowledge == host_dma_acknowledge_pin)
		else $error("host pins not passed through");
	a_burst_len_stop: assert property (periph_dma_acknowledge && bcnt_ff >= beff |-> !periph_dma_request)
		else $error("request held past burst length");
	a_clear_ends_dma: assert property (dma_enable_clear && dma_handler_enable |-> ##[1:2] dma_transfer_done)
		else $error("clear did not end transfer");
	a_done_handler_off: assert property (dma_transfer_done |-> !dma_handler_enable && !periph_dma_request)
		else $error("handler still on after termination");
	a_status_clear_evt: assert property (cmd_valid && cmd_op == udep_pkg::UDEP_CMD_READ_STATUS && !sie_tx_done
		&& !sie_rx_done && !sie_setup |=> !endpoint_event_flag[$past(cmd_endpoint)])
		else $error("status read left event flag");
	a_setup_flush_ctrl: assert property (sie_setup |=> buf_ping_full[0] && !buf_ping_full[1] && endpoint_event_flag[0])
		else $error("setup did not flush control in");
	a_setup_lock_cmd: assert property (sie_setup ##[1:4] (cmd_valid && cmd_op == udep_pkg::UDEP_CMD_VALIDATE
		&& cmd_endpoint < 4'h2) |=> cmd_refused)
		else $error("validate not refused after setup");
	a_bus_reset_clear: assert property (usb_bus_reset |=> endpoint_event_flag == 16'h0000 && buf_ping_full == 16'h0000
		&& !dma_handler_enable)
		else $error("bus reset left state");
	c_done: cover property (dma_transfer_done);
	c_refused: cover property (cmd_refused);
	c_burst_end: cover property (periph_dma_acknowledge && bcnt_ff == beff);
endmodule : udep_core_props

bind udep_core udep_core_props chk_u (.*);

// ---- testbench/udep_dma_partner.sv ----
// Purpose: fly-by dma controller facing udep_core
// Assumes: one clock, strobe held with ack
// Notes: grant_delay sets how slowly the bus is won
`timescale 1ns/1ps
module udep_dma_partner (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// handshake
	input wire logic req,
	output logic ack,
	input wire logic to_device,
	input wire logic [1:0] grant_delay,
	// data strobes
	output logic wr_strobe,
	output logic rd_strobe,
	output logic [7:0] wr_data,
	output logic [15:0] bytes_moved
);
	logic ack_ff = 1'b0;
	logic [1:0] wait_ff = 2'h0;
	logic [15:0] bytes_ff = 16'h0000;
	assign ack = ack_ff;
	assign wr_strobe = ack_ff & to_device;
	assign rd_strobe = ack_ff & !to_device;
	// released bus shows the inverted byte count, one past the last byte
	assign wr_data = ack_ff ? bytes_ff[7:0] : ~bytes_ff[7:0];
	assign bytes_moved = bytes_ff;
	// byte moved on an edge with request and ack high
	always_ff @(posedge clock)
	begin
		if (rst)
			bytes_ff <= 16'h0000;
		else if (req && ack_ff)
			bytes_ff <= bytes_ff + 16'h0001;
	end
	// bus won after grant_delay, released when request drops
	always_ff @(posedge clock)
	begin
		if (rst || !req)
		begin
			ack_ff <= 1'b0;
			wait_ff <= 2'h0;
		end
		else if (wait_ff == grant_delay)
			ack_ff <= 1'b1;
		else
			wait_ff <= wait_ff + 2'h1;
	end
endmodule : udep_dma_partner

// ---- testbench/udep_core_tb.sv ----
// Purpose: self-checking bench of udep_core
// Assumes: udep_dma_partner plays the dma controller
// Notes: seeded random sizes, bursts, lengths, grant delays
`timescale 1ns/1ps
module udep_core_tb;
	// design ports
	logic clock, rst, usb_bus_reset, cfg_write, endpoint_buffer_enable, endpoint_direction_bit;
	logic endpoint_isochronous_select, cfg_double_buffer, config_complete, alloc_overflow, cfg_reserved_size;
	logic dma_enable_set, dma_enable_clear, dma_handler_enable, dma_transfer_done, single_dma_channel_select;
	logic periph_dma_request, periph_dma_acknowledge, host_dma_request_pin, host_dma_acknowledge_pin;
	logic host_ctrl_dma_request, host_ctrl_dma_acknowledge, dma_write_strobe, dma_read_strobe, mem_wr_valid;
	logic mem_wr_ready, mem_rd_strobe, sie_tx_done, sie_rx_done, sie_setup, cmd_valid, cmd_refused;
	logic [3:0] cfg_index, endpoint_size_code, dma_endpoint_index, mem_wr_endpoint, sie_endpoint, cmd_endpoint;
	logic [4:0] dma_burst_bytes;
	logic [7:0] dma_write_data, dma_read_data, mem_wr_byte, mem_rd_byte, status_byte;
	logic [9:0] sie_rx_length;
	logic [15:0] alloc_total_bytes, dma_byte_count, buf_ping_full, buf_pong_full, endpoint_event_flag, m_bytes, base;
	udep_pkg::udep_cmd_t cmd_op;
	// partner and bench state
	logic m_req, m_ack, m_dir;
	logic [1:0] m_dly;
	logic [3:0] flg [6] = '{4'h0, 4'h0, 4'hD, 4'h8, 4'hA, 4'hB};
	int iso_size [16] = '{16, 32, 48, 64, 96, 128, 160, 192, 256, 320, 384, 512, 640, 768, 896, 1023};
	int err_total, num_checks, r, exp;
	udep_core dut_u (.*);
	udep_dma_partner far_u (.clock(clock), .rst(rst), .req(m_req), .ack(m_ack), .to_device(m_dir),
		.grant_delay(m_dly), .wr_strobe(dma_write_strobe), .rd_strobe(dma_read_strobe),
		.wr_data(dma_write_data), .bytes_moved(m_bytes));
	assign m_req = single_dma_channel_select ? host_dma_request_pin : periph_dma_request;
	assign periph_dma_acknowledge = m_ack & !single_dma_channel_select;
	assign host_dma_acknowledge_pin = m_ack & single_dma_channel_select;
	function automatic int psize(input logic iso, input logic [3:0] c);
		return iso ? iso_size[c] : ((c <= 4'h3) ? (8 << c) : 0);
	endfunction : psize
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
		num_checks++;
		if (got !== e)
		begin
			$display("ERROR %s expected %0h seen %0h", nm, e, got);
			err_total++;
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task automatic cfg(input logic [3:0] i, input logic [3:0] f, input logic [3:0] sz);
		@(negedge clock);
		cfg_write = 1'b1;
		{cfg_index, endpoint_buffer_enable, endpoint_direction_bit} = {i, f[3:2]};
		{endpoint_isochronous_select, cfg_double_buffer, endpoint_size_code} = {f[1:0], sz};
		@(negedge clock);
		cfg_write = 1'b0;
	endtask : cfg
	task automatic cmd(input udep_pkg::udep_cmd_t op, input logic [3:0] ep);
		@(negedge clock);
		{cmd_valid, cmd_op, cmd_endpoint} = {1'b1, op, ep};
		@(negedge clock);
		cmd_valid = 1'b0;
	endtask : cmd
	task automatic sie(input logic [2:0] k, input logic [3:0] ep, input logic [9:0] n);
		@(negedge clock);
		{sie_tx_done, sie_rx_done, sie_setup, sie_endpoint, sie_rx_length} = {k, ep, n};
		@(negedge clock);
		{sie_tx_done, sie_rx_done, sie_setup} = 3'h0;
	endtask : sie
	task automatic dma(input logic [1:0] sc, input logic [3:0] ep, input logic [4:0] b, input logic [15:0] n);
		@(negedge clock);
		m_dly = 2'($urandom % 4);
		base = m_bytes;
		{dma_enable_set, dma_enable_clear, dma_endpoint_index, dma_burst_bytes, dma_byte_count} = {sc, ep, b, n};
		@(negedge clock);
		{dma_enable_set, dma_enable_clear} = 2'h0;
	endtask : dma
	task automatic idle();
		int k = 0;
		for (int t = 0; t < 400 && k < 4; t++)
		begin
			@(negedge clock);
			k = (m_req || m_ack) ? 0 : k + 1;
		end
	endtask : idle
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial
	begin
		#80000;
		err_total++;
		complete_run();
	end
	initial
	begin
		{rst, usb_bus_reset, cfg_write, dma_enable_set, dma_enable_clear, single_dma_channel_select} = 6'h20;
		{host_ctrl_dma_request, mem_wr_ready, sie_tx_done, sie_rx_done, sie_setup, cmd_valid, m_dir} = 7'h01;
		{cfg_index, endpoint_buffer_enable, endpoint_direction_bit, endpoint_isochronous_select} = 7'h00;
		{cfg_double_buffer, endpoint_size_code, dma_endpoint_index, dma_burst_bytes, dma_byte_count} = 30'h0;
		{sie_endpoint, sie_rx_length, cmd_endpoint, m_dly, mem_rd_byte} = {20'h0, 8'h3C};
		cmd_op = udep_pkg::UDEP_CMD_VALIDATE;
		{err_total, num_checks} = 64'h0;
		r = $urandom(32'h3287);
		repeat (4) @(negedge clock);
		rst = 1'b0;
		r = $urandom % 16;
		for (int i = 0; i < 16; i++)
			cfg(i[3:0], (i < 6) ? flg[i] : 4'h0, (i == 4) ? r[3:0] : ((i == 5) ? 4'hF : 4'h0));
		exp = 128 + 3 * psize(0, 4'h0) + psize(1, r[3:0]) + 2 * psize(1, 4'hF);
		chk("config_complete", 1, config_complete);
		chk("alloc_total_bytes", exp, alloc_total_bytes);
		chk("alloc_overflow", exp > 2462, alloc_overflow);
		{endpoint_size_code, endpoint_isochronous_select} = 5'h08;
		#1 chk("reserved size", 1, cfg_reserved_size);
		endpoint_isochronous_select = 1'b1;
		#1 chk("iso size", 0, cfg_reserved_size);
		r = 1 + $urandom % 16;
		dma(2'h2, 4'h2, r[4:0], 16'h0000);
		idle();
		chk("stalled bytes", base + 8, m_bytes);
		chk("fifo endpoint", 2, mem_wr_endpoint);
		chk("fifo byte", base[7:0], mem_wr_byte);
		mem_wr_ready = 1'b1;
		idle();
		chk("tx bytes", base + 16, m_bytes);
		chk("tx full", 2'h3, {buf_pong_full[2], buf_ping_full[2]});
		chk("fifo drained", 0, mem_wr_valid);
		dma(2'h1, 4'h2, r[4:0], 16'h0000);
		chk("handler cleared", 0, dma_handler_enable);
		sie(3'h4, 4'h2, 10'h000);
		sie(3'h4, 4'h2, 10'h000);
		cmd(udep_pkg::UDEP_CMD_READ_STATUS, 4'h2);
		chk("status", 8'h4B, status_byte);
		chk("event cleared", 0, endpoint_event_flag[2]);
		dma(2'h2, 4'h2, 5'h10, 16'h0005);
		idle();
		chk("count bytes", base + 5, m_bytes);
		chk("partial valid", 2'h1, {buf_pong_full[2], buf_ping_full[2]});
		m_dir = 1'b0;
		r = 1 + $urandom % 8;
		sie(3'h2, 4'h3, r[9:0]);
		chk("rx full", 1, buf_ping_full[3]);
		dma(2'h2, 4'h3, 5'h04, 16'h0000);
		idle();
		chk("rx bytes", base + r, m_bytes);
		chk("rx freed", 0, buf_ping_full[3]);
		chk("rx data", 8'h3C, dma_read_data);
		dma(2'h1, 4'h3, 5'h04, 16'h0000);
		sie(3'h2, 4'h3, 10'h008);
		dma(2'h2, 4'h3, 5'h04, 16'h0002);
		idle();
		chk("rx count", base + 2, m_bytes);
		chk("rx partial freed", 0, buf_ping_full[3]);
		chk("rx handler off", 0, dma_handler_enable);
		cmd(udep_pkg::UDEP_CMD_VALIDATE, 4'h1);
		sie(3'h1, 4'h0, 10'h008);
		chk("setup flush", 2'h1, buf_ping_full[1:0]);
		cmd(udep_pkg::UDEP_CMD_VALIDATE, 4'h1);
		chk("validate refused", 1, cmd_refused);
		cmd(udep_pkg::UDEP_CMD_CLEAR, 4'h0);
		chk("clear refused", 1, cmd_refused);
		cmd(udep_pkg::UDEP_CMD_ACK_SETUP, 4'h0);
		cmd(udep_pkg::UDEP_CMD_ACK_SETUP, 4'h1);
		cmd(udep_pkg::UDEP_CMD_VALIDATE, 4'h1);
		chk("validate taken", 0, cmd_refused);
		cmd(udep_pkg::UDEP_CMD_CLEAR, 4'h0);
		chk("ctrl buffers", 2'h2, buf_ping_full[1:0]);
		{m_dir, single_dma_channel_select} = 2'h3;
		dma(2'h2, 4'h2, 5'h03, 16'h0000);
		idle();
		chk("routed bytes", base + 8, m_bytes);
		single_dma_channel_select = 1'b0;
		dma(2'h2, 4'h1, 5'h03, 16'h0000);
		chk("ctrl index req", 0, periph_dma_request);
		usb_bus_reset = 1'b1;
		repeat (2) @(negedge clock);
		usb_bus_reset = 1'b0;
		chk("bus reset flags", 0, buf_ping_full | buf_pong_full | endpoint_event_flag);
		cmd(udep_pkg::UDEP_CMD_READ_STATUS, 4'h2);
		chk("ep disabled", 0, status_byte[0]);
		cmd(udep_pkg::UDEP_CMD_READ_STATUS, 4'h1);
		chk("ctrl enabled", 2'h3, status_byte[1:0]);
		complete_run();
	end
endmodule : udep_core_tb
